// file: dv/tb_top.sv
// Purpose: Self-checking bench for the cell status and tally block.
// Assumes: Slave answers after setup; the bench waits a bounded time.
// Notes: Sent tally runs past 16 bits so its high byte is exercised.
`timescale 1ns/1ps
module tb_top import acrsc_pkg::*;;
   logic i_clk;
   logic i_resetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   logic lvl;
   logic [6:0] pls;
   logic sent;
   logic [3:0] strb;
   int error_cnt = 0;
   int n_tests = 0;

   // Device under test, event bit n drives status bit n, event bit 4 left unconnected
   acrsc_top i_acrsc_top (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_delineation_lost(lvl), .i_header_error_uncorrectable(pls[6]),
      .i_header_error_fixed(pls[5]), .i_valid_cell_seen(pls[3]),
      .i_idle_cell_seen(pls[2]), .i_screened_cell_rejected(pls[1]),
      .i_flow_control_field_set(pls[0]), .i_cell_sent(sent));

   // Clock at 50 ns
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
      ba = {2'b00, idx, 2'b00};
   endfunction

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; p pulses events during the setup cycle
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [7:0] wd, input logic [6:0] p,
      output logic [31:0] rd, output logic er);
      int k;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      pls <= p;
      @(posedge i_clk);
      penable <= 1'b1;
      pls <= 7'h00;
      k = 0;
      // Pready and data are taken at the rising edge that sees pready
      @(posedge i_clk);
      while (o_pready !== 1'b1 && k < 8) begin
         @(posedge i_clk);
         k++;
      end
      if (o_pready !== 1'b1) begin
         error_cnt++;
         $display("Error pready expected 1 seen 0");
         give_verdict();
      end else begin
         rd = o_prdata;
         er = o_pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rdx(input logic [ADDR_W-1:0] a, input logic [6:0] p,
      input logic [31:0] e, input logic ee);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 8'h00, p, rd, er);
      chk("prdata", e, rd);
      chk("pslverr", {31'h0, ee}, {31'h0, er});
   endtask

   task automatic wrx(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, ba(idx), d, 7'h00, rd, er);
   endtask

   // Holds pulse pattern p and sent s for n cycles
   task automatic pulse(input logic [6:0] p, input logic s, input int n);
      @(posedge i_clk);
      pls <= p;
      sent <= s;
      repeat (n) @(posedge i_clk);
      pls <= 7'h00;
      sent <= 1'b0;
   endtask

   task automatic t_reset();
      rdx(ba(IDX_RX_CELL_STATUS), 7'h00, 32'h0, 1'b0);
      rdx(ba(IDX_TALLY_CTRL), 7'h00, 32'h7, 1'b0);
   endtask

   // Each event bit sticks until read, then clears
   task automatic t_status();
      int b;
      logic [ADDR_W-1:0] sa;
      sa = ba(IDX_RX_CELL_STATUS);
      for (b = 0; b < 7; b++) begin
         if (b != 4) begin
            pulse(7'h01 << b, 1'b0, 1);
            repeat (3) @(posedge i_clk);
            rdx(sa, 7'h00, 32'h1 << b, 1'b0);
            rdx(sa, 7'h00, 32'h0, 1'b0);
         end
      end
      // Valid and flow control events land in the clearing read
      rdx(sa, 7'h09, 32'h0, 1'b0);
      rdx(sa, 7'h00, 32'h9, 1'b0);
   endtask

   // Live loss bit and rising-edge-only loss tally
   task automatic t_loss();
      lvl <= 1'b1;
      rdx(ba(IDX_RX_CELL_STATUS), 7'h00, 32'h80, 1'b0);
      rdx(ba(IDX_RX_CELL_STATUS), 7'h00, 32'h80, 1'b0);
      lvl <= 1'b0;
      rdx(ba(IDX_RX_CELL_STATUS), 7'h00, 32'h0, 1'b0);
      repeat (2) begin
         @(posedge i_clk);
         lvl <= 1'b1;
         repeat (3) @(posedge i_clk);
         lvl <= 1'b0;
      end
      rdx(ba(IDX_LOSS_COUNT), 7'h00, 32'h3, 1'b0);
      rdx(ba(IDX_LOSS_COUNT), 7'h00, 32'h0, 1'b0);
   endtask

   // Idle tally: snapshot, clears, increment during low read
   task automatic t_idle();
      // One idle cell from the status test plus 300 here: 0x12d
      pulse(7'h04, 1'b0, 300);
      rdx(ba(IDX_IDLE_LOW), 7'h04, 32'h2d, 1'b0);
      pulse(7'h04, 1'b0, 5);
      rdx(ba(IDX_IDLE_MID), 7'h00, 32'h01, 1'b0);
      rdx(ba(IDX_IDLE_HIGH), 7'h00, 32'h00, 1'b0);
      rdx(ba(IDX_IDLE_MID), 7'h00, 32'h00, 1'b0);
      rdx(ba(IDX_IDLE_LOW), 7'h00, 32'h06, 1'b0);
      wrx(IDX_TALLY_CTRL, 8'h06);
      pulse(7'h04, 1'b0, 3);
      rdx(ba(IDX_IDLE_LOW), 7'h00, 32'h00, 1'b0);
      wrx(IDX_TALLY_CTRL, 8'h07);
      // Write with byte lane 0 off leaves control alone
      strb <= 4'h0;
      wrx(IDX_TALLY_CTRL, 8'h00);
      strb <= 4'h1;
      rdx(ba(IDX_TALLY_CTRL), 7'h00, 32'h07, 1'b0);
   endtask

   // Sent tally past 16 bits: 0x10102
   task automatic t_tx();
      pulse(7'h00, 1'b1, 32'h10102);
      rdx(ba(IDX_TX_LOW), 7'h00, 32'h02, 1'b0);
      rdx(ba(IDX_TX_MID), 7'h00, 32'h01, 1'b0);
      rdx(ba(IDX_TX_HIGH), 7'h00, 32'h01, 1'b0);
      rdx(ba(IDX_TX_HIGH), 7'h00, 32'h00, 1'b0);
   endtask

   // Unmapped and misaligned addresses, ignored status write
   task automatic t_errors();
      logic [31:0] rd;
      logic er;
      rdx(ba(8'h2e), 7'h00, 32'h0, 1'b1);
      rdx(ba(IDX_RX_CELL_STATUS) | 12'h001, 7'h00, 32'h0, 1'b1);
      apb(1'b1, ba(IDX_RX_CELL_STATUS), 8'hff, 7'h00, rd, er);
      chk("status write pslverr", 32'h0, {31'h0, er});
      chk("status write prdata", 32'h0, rd);
      rdx(ba(IDX_RX_CELL_STATUS), 7'h00, 32'h04, 1'b0);
   endtask

   // Main sequence
   initial begin
      i_resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      lvl = 1'b0;
      pls = 7'h00;
      sent = 1'b0;
      strb = 4'h1;
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_reset();
      t_status();
      t_loss();
      t_idle();
      t_tx();
      t_errors();
      give_verdict();
   end
endmodule

// file: logic/acrsc_pkg.sv
// Purpose: Constants for the receive cell status and tally block.
// Assumes: Registers are one byte each, one aligned APB word apart.
// Notes: Byte address of a register is four times its index.
package acrsc_pkg;

   // APB address width
   localparam int unsigned ADDR_W = 12;

   // Register indices
   localparam logic [7:0] IDX_RX_CELL_STATUS = 8'h2f;
   localparam logic [7:0] IDX_IDLE_LOW = 8'h30;
   localparam logic [7:0] IDX_IDLE_MID = 8'h31;
   localparam logic [7:0] IDX_IDLE_HIGH = 8'h32;
   localparam logic [7:0] IDX_LOSS_COUNT = 8'h33;
   localparam logic [7:0] IDX_TX_LOW = 8'h34;
   localparam logic [7:0] IDX_TX_MID = 8'h35;
   localparam logic [7:0] IDX_TX_HIGH = 8'h36;
   localparam logic [7:0] IDX_TALLY_CTRL = 8'h3e;

   // Status byte fields
   localparam int unsigned BIT_DELIN_LOST = 7;
   localparam int unsigned BIT_HDR_UNCORR = 6;
   localparam int unsigned BIT_HDR_FIXED = 5;
   localparam int unsigned BIT_VALID = 3;
   localparam int unsigned BIT_IDLE = 2;
   localparam int unsigned BIT_SCREENED = 1;
   localparam int unsigned BIT_GFC = 0;

   // Control byte fields
   localparam int unsigned CTRL_IDLE_EN = 0;
   localparam int unsigned CTRL_TX_EN = 1;
   localparam int unsigned CTRL_LOSS_EN = 2;

   // Widths and reset values
   localparam int unsigned TALLY_W = 19;
   localparam int unsigned LOSS_W = 8;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h07;
   localparam logic [7:0] LOSS_RESET = 8'h00;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'b00, idx, 2'b00};
   endfunction

endpackage

// file: logic/acrsc_tally.sv
// Purpose: 19-bit clear-on-read tally read one byte at a time.
// Assumes: Low byte is read before the middle and high bytes.
// Notes: Low read clears the count and freezes the upper bytes.
`timescale 1ns/1ps
module acrsc_tally import acrsc_pkg::*; #(
   parameter int unsigned W = TALLY_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Count and read strobes
   input wire logic i_count,
   input wire logic i_take_low,
   input wire logic i_take_mid,
   input wire logic i_take_high,
   // Byte views
   output logic [7:0] o_low,
   output logic [7:0] o_mid,
   output logic [7:0] o_high
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic [W-9:0] snap_reg;
   logic [W-9:0] snap_next;
   logic [W-1:0] inc_w;

   // Increment that lands on a low read survives the clear
   assign inc_w = {{(W-1){1'b0}}, i_count};
   assign count_next = i_take_low ? inc_w : count_reg + inc_w; // R18

   // Upper bytes frozen on low read, each cleared on its own read
   assign snap_next[7:0] = i_take_low ? count_reg[15:8] :
      (i_take_mid ? 8'h00 : snap_reg[7:0]); // R17
   assign snap_next[W-9:8] = i_take_low ? count_reg[W-1:16] :
      (i_take_high ? {(W-16){1'b0}} : snap_reg[W-9:8]); // R14

   // Count and snapshot storage
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_reg <= '0;
         snap_reg <= '0;
      end else begin
         count_reg <= count_next;
         snap_reg <= snap_next;
      end
   end

   // Byte views, reserved high bits as zero
   assign o_low = count_reg[7:0];
   assign o_mid = snap_reg[7:0];
   assign o_high = {{(24-W){1'b0}}, snap_reg[W-9:8]}; // R16

endmodule

// file: logic/acrsc_top.sv
// Purpose: Receive cell status byte and cell tallies over APB.
// Assumes: Event inputs are one-cycle pulses on i_clk.
// Notes: Reads answer with one wait-free access cycle.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps

// Contract
// (R01) Status byte clears whenever software reads it
// (R02) Status event bits stay set until read
// (R03) Bit 7 shows present delineation loss state
// (R04) Bit 6 flags uncorrectable header error
// (R05) Bit 5 flags corrected header error
// (R06) Bit 3 flags valid cell received
// (R07) Bit 2 flags idle header match
// (R08) Bit 1 flags screening rejection
// (R09) Bit 0 flags nonzero flow control field
// (R10) Software ignores reserved status bit 4
// (R11) 19-bit idle cell tally, three bytes
// (R12) 19-bit sent cell tally, three bytes
// (R13) 8-bit tally counts delineation losses only
// (R14) Each tally byte clears on its read
// (R15) Software reads low byte first
// (R16) High byte bits 7..3 read zero
// (R17) Low read freezes upper bytes consistently
// (R18) Coinciding events survive clear-on-read
module acrsc_top import acrsc_pkg::*; (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Receive cell conditions
   input wire logic i_delineation_lost,
   input wire logic i_header_error_uncorrectable,
   input wire logic i_header_error_fixed,
   input wire logic i_valid_cell_seen,
   input wire logic i_idle_cell_seen,
   input wire logic i_screened_cell_rejected,
   input wire logic i_flow_control_field_set,
   // Transmit cell event
   input wire logic i_cell_sent
);

   // Bus phase decode
   logic setup;
   logic rd;
   logic wr_commit;
   logic aligned;
   assign setup = i_psel & ~i_penable;
   assign rd = setup & ~i_pwrite;
   assign wr_commit = i_psel & i_penable & o_pready & i_pwrite;
   assign aligned = (i_paddr[1:0] == 2'b00);

   // Register address hits
   logic hit_status;
   logic hit_idle_low;
   logic hit_idle_mid;
   logic hit_idle_high;
   logic hit_loss;
   logic hit_tx_low;
   logic hit_tx_mid;
   logic hit_tx_high;
   logic hit_ctrl;
   logic mapped;
   assign hit_status = (i_paddr == byte_addr(IDX_RX_CELL_STATUS));
   assign hit_idle_low = (i_paddr == byte_addr(IDX_IDLE_LOW));
   assign hit_idle_mid = (i_paddr == byte_addr(IDX_IDLE_MID));
   assign hit_idle_high = (i_paddr == byte_addr(IDX_IDLE_HIGH));
   assign hit_loss = (i_paddr == byte_addr(IDX_LOSS_COUNT));
   assign hit_tx_low = (i_paddr == byte_addr(IDX_TX_LOW));
   assign hit_tx_mid = (i_paddr == byte_addr(IDX_TX_MID));
   assign hit_tx_high = (i_paddr == byte_addr(IDX_TX_HIGH));
   assign hit_ctrl = (i_paddr == byte_addr(IDX_TALLY_CTRL));
   assign mapped = aligned & (hit_status | hit_idle_low | hit_idle_mid |
      hit_idle_high | hit_loss | hit_tx_low | hit_tx_mid | hit_tx_high |
      hit_ctrl);

   // Read side-effect strobes, taken in the setup cycle
   logic rd_status;
   logic rd_idle_low;
   logic rd_idle_mid;
   logic rd_idle_high;
   logic rd_loss;
   logic rd_tx_low;
   logic rd_tx_mid;
   logic rd_tx_high;
   assign rd_status = rd & hit_status;
   assign rd_idle_low = rd & hit_idle_low;
   assign rd_idle_mid = rd & hit_idle_mid;
   assign rd_idle_high = rd & hit_idle_high;
   assign rd_loss = rd & hit_loss;
   assign rd_tx_low = rd & hit_tx_low;
   assign rd_tx_mid = rd & hit_tx_mid;
   assign rd_tx_high = rd & hit_tx_high;

   // Tally control register
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   assign ctrl_next = (wr_commit & hit_ctrl & i_pstrb[0]) ?
      i_pwdata[7:0] : ctrl_reg;

   // Status events, reserved bit 4 and live bit 7 never stored
   logic [7:0] status_ev;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] status_view;
   assign status_ev[BIT_DELIN_LOST] = 1'b0;
   assign status_ev[BIT_HDR_UNCORR] = i_header_error_uncorrectable; // R04
   assign status_ev[BIT_HDR_FIXED] = i_header_error_fixed; // R05
   assign status_ev[4] = 1'b0; // R10
   assign status_ev[BIT_VALID] = i_valid_cell_seen; // R06
   assign status_ev[BIT_IDLE] = i_idle_cell_seen; // R07
   assign status_ev[BIT_SCREENED] = i_screened_cell_rejected; // R08
   assign status_ev[BIT_GFC] = i_flow_control_field_set; // R09

   // Sticky bits, cleared by a read, set wins over clear
   assign status_next = (rd_status ? 8'h00 : status_reg) |
      status_ev; // R01 R02 R18

   // Read view: bit 7 is the live delineation state
   assign status_view = {i_delineation_lost, status_reg[6:0]}; // R03

   // Delineation loss tally, counts only the loss edge
   logic delin_prev_reg;
   logic loss_rise;
   logic loss_inc;
   logic [LOSS_W-1:0] loss_reg;
   logic [LOSS_W-1:0] loss_next;
   assign loss_rise = i_delineation_lost & ~delin_prev_reg; // R13
   assign loss_inc = loss_rise & ctrl_reg[CTRL_LOSS_EN];
   assign loss_next = rd_loss ? {{(LOSS_W-1){1'b0}}, loss_inc} :
      loss_reg + {{(LOSS_W-1){1'b0}}, loss_inc}; // R13 R14 R18

   // Idle and sent cell tallies
   logic idle_inc;
   logic tx_inc;
   logic [7:0] idle_low;
   logic [7:0] idle_mid;
   logic [7:0] idle_high;
   logic [7:0] tx_low;
   logic [7:0] tx_mid;
   logic [7:0] tx_high;
   assign idle_inc = i_idle_cell_seen & ctrl_reg[CTRL_IDLE_EN];
   assign tx_inc = i_cell_sent & ctrl_reg[CTRL_TX_EN];

   // Idle cell tally bytes
   acrsc_tally #(
      .W(TALLY_W)
   ) u_idle_tally ( // R11
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_count(idle_inc),
      .i_take_low(rd_idle_low),
      .i_take_mid(rd_idle_mid),
      .i_take_high(rd_idle_high),
      .o_low(idle_low),
      .o_mid(idle_mid),
      .o_high(idle_high)
   );

   // Sent cell tally bytes
   acrsc_tally #(
      .W(TALLY_W)
   ) u_tx_tally ( // R12
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_count(tx_inc),
      .i_take_low(rd_tx_low),
      .i_take_mid(rd_tx_mid),
      .i_take_high(rd_tx_high),
      .o_low(tx_low),
      .o_mid(tx_mid),
      .o_high(tx_high)
   );

   // Read data select
   logic [7:0] rd_byte;
   logic [31:0] prdata_next;
   assign rd_byte = !mapped ? 8'h00 :
      hit_status ? status_view :
      hit_idle_low ? idle_low :
      hit_idle_mid ? idle_mid :
      hit_idle_high ? idle_high :
      hit_loss ? loss_reg :
      hit_tx_low ? tx_low :
      hit_tx_mid ? tx_mid :
      hit_tx_high ? tx_high :
      ctrl_reg;
   assign prdata_next = rd ? {24'h000000, rd_byte} :
      (setup ? 32'h00000000 : o_prdata);

   // Bus answer registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_prdata <= 32'h00000000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_prdata <= prdata_next;
         o_pready <= setup;
         o_pslverr <= setup & ~mapped;
      end
   end

   // Status, control and loss tally registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_reg <= STATUS_RESET;
         ctrl_reg <= CTRL_RESET;
         loss_reg <= LOSS_RESET;
         delin_prev_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         ctrl_reg <= ctrl_next;
         loss_reg <= loss_next;
         delin_prev_reg <= i_delineation_lost;
      end
   end

   // Checks
   sequence s_setup;
      i_psel && !i_penable;
   endsequence

   sequence s_answer;
      o_pready ##1 !o_pready;
   endsequence

   a_bus_answer: // APB answer timing, local port choice
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_setup |=> s_answer)
   else $error("pready not one cycle after setup");

   a_status_clear: // R01
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_status && (status_ev == 8'h00) |=> status_reg == 8'h00)
   else $error("status byte not cleared by read");

   a_status_sticky: // R02
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      status_reg[BIT_HDR_FIXED] && !rd_status [*2]
      |=> status_reg[BIT_HDR_FIXED])
   else $error("sticky status bit dropped without read");

   a_uncorr_sets: // R04
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_header_error_uncorrectable |=> status_reg[BIT_HDR_UNCORR])
   else $error("uncorrectable error not flagged");

   a_live_loss_bit: // R03
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_status |=> o_prdata[7] == $past(i_delineation_lost))
   else $error("bit 7 does not show live delineation state");

   a_set_over_clear: // R18
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_status && i_valid_cell_seen ##1 !rd_status
      |=> status_reg[BIT_VALID])
   else $error("event lost on status clear");

   a_loss_rise_count: // R13
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      loss_inc && !rd_loss |=> loss_reg == $past(loss_reg) + 8'h01)
   else $error("delineation loss not counted");

   a_loss_regain: // R13
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      $fell(i_delineation_lost) && !rd_loss |=> $stable(loss_reg))
   else $error("regain of delineation was counted");

   a_high_reserved: // R16
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_idle_high || rd_tx_high |=> o_prdata[31:3] == 29'h0)
   else $error("reserved high byte bits not zero");

   a_low_take: // R14
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_tx_low |=> tx_low == {7'h00, $past(tx_inc)})
   else $error("low tally byte not cleared by read");

   a_unmapped_err: // APB error answer, local port choice
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      setup && !mapped |=> o_pslverr && o_pready && o_prdata == 32'h0)
   else $error("unmapped access not refused");

   // Cycles in which a frozen upper byte must hold still
   sequence s_idle_mid_quiet;
      !rd_idle_low && !rd_idle_mid;
   endsequence

   sequence s_tx_high_quiet;
      !rd_tx_low && !rd_tx_high;
   endsequence

   a_fixed_sets: // R05
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_header_error_fixed |=> status_reg[BIT_HDR_FIXED])
   else $error("corrected header error not flagged");

   a_valid_sets: // R06
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_valid_cell_seen |=> status_reg[BIT_VALID])
   else $error("valid cell not flagged");

   a_idle_sets: // R07
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_idle_cell_seen |=> status_reg[BIT_IDLE])
   else $error("idle cell not flagged");

   a_screen_sets: // R08
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_screened_cell_rejected |=> status_reg[BIT_SCREENED])
   else $error("screened cell not flagged");

   a_gfc_sets: // R09
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_flow_control_field_set |=> status_reg[BIT_GFC])
   else $error("nonzero flow control field not flagged");

   a_idle_count: // R11
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      idle_inc && !rd_idle_low |=> idle_low == $past(idle_low) + 8'h01)
   else $error("idle cell not counted");

   a_tx_count: // R12
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      tx_inc && !rd_tx_low |=> tx_low == $past(tx_low) + 8'h01)
   else $error("sent cell not counted");

   a_mid_frozen: // R17
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_idle_mid_quiet |=> $stable(idle_mid))
   else $error("idle middle byte moved without a read");

   a_high_frozen: // R17
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_tx_high_quiet |=> $stable(tx_high))
   else $error("sent high byte moved without a read");

   a_mid_clear: // R14
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_idle_mid |=> idle_mid == 8'h00)
   else $error("idle middle byte not cleared by read");

   a_loss_clear: // R14
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_loss |=> loss_reg == {7'h00, $past(loss_inc)})
   else $error("loss tally not cleared by read");

   a_bit4_zero: // R10
   assert property (@(posedge i_clk) disable iff (!i_resetn)
      rd_status |=> o_prdata[4] == 1'b0)
   else $error("reserved status bit not zero");

endmodule
